//--- rtl/dcfm_pkg.sv
/*
 * Shared constants and types of the dual channel fault manager.
 * Assumes byte addresses on a 32-bit Avalon-MM bus, one register per word.
 */
package dcfm_pkg;
    localparam int ADDR_W = 5;
    localparam int NCH = 2;
    localparam int MFT_W = 14;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_RUN_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_FEN_A = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_FEN_B = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_LATCH = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_MFT = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT_A = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_STAT_B = 5'h18;
    localparam logic [ADDR_W-1:0] OFF_CH_STATE = 5'h1c;
    // Run control fields: run bits at [1:0]
    localparam int POS_EXT_CLK = 2;
    localparam int POS_PIN_CLR = 3;
    // Per-channel field stride inside shared registers
    localparam int CH_STRIDE = 4;
    // fault_enable_reg_a fields per channel
    localparam int POS_HV_ON = 0;
    localparam int POS_LV_ON = 1;
    localparam int POS_RAMP_ON = 2;
    // fault_enable_reg_b fields per channel
    localparam int POS_SWITCH_CURRENT_CAP_FAULT_ON = 0;
    localparam int POS_OC_ON = 1;
    localparam int POS_SNO_ON = 2;
    // latch_policy_reg fields per channel
    localparam int POS_HV_LAT = 0;
    localparam int POS_LV_LAT = 1;
    localparam int POS_SWITCH_CURRENT_CAP_FAULT_LAT = 2;
    localparam int POS_OC_LAT = 3;
    // fault_status_reg_a: per channel hv, lv, switch_current_cap_fault at 3*ch; common above
    localparam int POS_ST_TRO = 6;
    localparam int POS_ST_TW = 7;
    localparam int POS_ST_POR = 8;
    // Reset values
    localparam logic [7:0] RST_FEN_A = 8'h33;
    localparam logic [7:0] RST_FEN_B = 8'h77;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_MFT = 8'h00;
    // Main fault timer span in channel clock periods
    localparam logic [MFT_W-1:0] MFT_MIN = 14'h03e8;
    localparam logic [MFT_W-1:0] MFT_MAX = 14'h3fff;
    localparam logic [MFT_W-1:0] MFT_STEP = 14'h0401;

    typedef struct packed {
        logic hv;
        logic lv;
        logic switch_current_cap_fault;
        logic oc;
        logic uc;
        logic sense_open;
        logic fb_open;
        logic ramp_busy;
    } dcfm_ch_cond_t;

    typedef struct packed {
        logic supply_lockout;
        logic thermal_shutdown;
        logic thermal_warning;
        logic timing_open;
        logic por;
    } dcfm_common_t;

    typedef enum logic [1:0] {
        CH_OFF = 2'h0,
        CH_RUN = 2'h1,
        CH_WAIT = 2'h3,
        CH_LATCHED = 2'h2
    } dcfm_ch_state_t;
endpackage

//--- rtl/dcfm_fault_manager.sv
/*
 * Fault supervisor for two switching channels: flags, latch policy,
 * main fault timer, read-to-clear status and active-low fault pins.
 * Assumes all inputs synchronous to clk_in; ch_tick_in is a one-cycle
 * pulse per channel switching period; Avalon-MM master holds requests.
 */
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/10ps
module dcfm_fault_manager #(
    parameter int MFT_W = dcfm_pkg::MFT_W
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic [dcfm_pkg::ADDR_W-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire dcfm_pkg::dcfm_ch_cond_t [1:0] ch_cond_in,
    input wire dcfm_pkg::dcfm_common_t common_in,
    input wire logic [1:0] ch_tick_in,
    input wire logic fault_b_in,
    output logic [1:0] ch_on_out,
    output logic [1:0] soft_start_out,
    output logic [1:0] hv_hyst_out,
    output logic fault_a_out,
    output logic fault_a_oe_n_out,
    output logic fault_b_out,
    output logic fault_b_oe_n_out,
    output logic ext_clk_out
);
    localparam int NCH = dcfm_pkg::NCH;
    localparam int SW = dcfm_pkg::CH_STRIDE;

    function automatic logic [MFT_W-1:0] mft_limit(input logic [3:0] code);
        logic [MFT_W-1:0] v;
        v = MFT_W'(dcfm_pkg::MFT_MIN) + MFT_W'(code * dcfm_pkg::MFT_STEP);
        // Top code saturates at the counter's full range
        if (code == 4'hf) begin
            v = MFT_W'(dcfm_pkg::MFT_MAX);
        end
        return v;
    endfunction

    function automatic logic ch_bit(input logic [7:0] r, input int ch, input int pos);
        return r[ch * SW + pos];
    endfunction

    // Set wins; a read clears only bits it has shown whose cause is gone
    function automatic logic [8:0] stat_upd(input logic [8:0] q, input logic [8:0] shown,
        input logic [8:0] now, input logic done);
        logic [8:0] gone;
        gone = {9{done}} & shown & ~now;
        return (q & ~gone) | now;
    endfunction

    // Register file state
    logic [1:0] run_q, run_d;
    logic ext_clk_sel_q, ext_clk_sel_d;
    logic [7:0] fen_a_q, fen_a_d;
    logic [7:0] fen_b_q, fen_b_d;
    logic [7:0] latch_q, latch_d;
    logic [7:0] mft_q, mft_d;
    logic [8:0] stat_a_q, stat_a_d;
    logic [5:0] stat_b_q, stat_b_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rewrite_q, rewrite_d;
    logic pin_clr_q, pin_clr_d;

    // Channel state
    dcfm_pkg::dcfm_ch_state_t st_q [NCH];
    dcfm_pkg::dcfm_ch_state_t st_d [NCH];
    logic [MFT_W-1:0] cnt_q [NCH];
    logic [MFT_W-1:0] cnt_d [NCH];
    logic [3:0] prev_q [NCH];
    logic [3:0] prev_d [NCH];
    logic tro_prev_q, tro_prev_d;
    logic [1:0] ss_q, ss_d;
    logic [1:0] pin_q, pin_d;
    logic ext_clk_q, ext_clk_d;

    // Combinational flags
    logic [1:0] hv_flag, lv_flag, switch_current_cap_fault_flag, oc_flag, sno_flag, fbo_flag, uc_flag;
    logic [1:0] pin_evt;
    logic [8:0] stat_a_now;
    logic [5:0] stat_b_now;
    logic common_off;
    logic access_done, rd_done_a, rd_done_b;

    // One wait state so read data always comes from a flop
    assign access_done = ack_q & (read_in | write_in);
    assign waitrequest_out = (read_in | write_in) & ~ack_q;
    assign common_off = common_in.supply_lockout | common_in.thermal_shutdown;

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            // Enable-bit faults gated; the rest always live
            hv_flag[i] = ch_cond_in[i].hv & ch_bit(fen_a_q, i, dcfm_pkg::POS_HV_ON);
            lv_flag[i] = ch_cond_in[i].lv & ch_bit(fen_a_q, i, dcfm_pkg::POS_LV_ON)
                & (ch_bit(fen_a_q, i, dcfm_pkg::POS_RAMP_ON) | ~ch_cond_in[i].ramp_busy);
            switch_current_cap_fault_flag[i] = ch_cond_in[i].switch_current_cap_fault & ch_bit(fen_b_q, i, dcfm_pkg::POS_SWITCH_CURRENT_CAP_FAULT_ON);
            oc_flag[i] = ch_cond_in[i].oc & ch_bit(fen_b_q, i, dcfm_pkg::POS_OC_ON);
            sno_flag[i] = ch_cond_in[i].sense_open & ch_bit(fen_b_q, i, dcfm_pkg::POS_SNO_ON);
            fbo_flag[i] = ch_cond_in[i].fb_open;
            uc_flag[i] = ch_cond_in[i].uc;
            pin_evt[i] = hv_flag[i] | lv_flag[i] | switch_current_cap_fault_flag[i] | oc_flag[i] | sno_flag[i] | fbo_flag[i]
                | common_in.timing_open | common_in.thermal_shutdown | common_in.por;
        end
        stat_a_now = '0;
        stat_b_now = '0;
        for (int i = 0; i < NCH; i++) begin
            stat_a_now[3 * i] = hv_flag[i] | fbo_flag[i];
            stat_a_now[3 * i + 1] = lv_flag[i];
            stat_a_now[3 * i + 2] = switch_current_cap_fault_flag[i];
            stat_b_now[3 * i] = oc_flag[i];
            stat_b_now[3 * i + 1] = uc_flag[i];
            stat_b_now[3 * i + 2] = sno_flag[i];
        end
        stat_a_now[dcfm_pkg::POS_ST_TRO] = common_in.timing_open;
        stat_a_now[dcfm_pkg::POS_ST_TW] = common_in.thermal_warning;
        stat_a_now[dcfm_pkg::POS_ST_POR] = common_in.por;
    end

    // Bus side: decode, writes, read data, read-to-clear status
    always_comb begin
        run_d = run_q;
        ext_clk_sel_d = ext_clk_sel_q;
        fen_a_d = fen_a_q;
        fen_b_d = fen_b_q;
        latch_d = latch_q;
        mft_d = mft_q;
        rewrite_d = 2'h0;
        pin_clr_d = 1'b0;
        ack_d = (read_in | write_in) & ~ack_q;
        rdata_d = rdata_q;
        rd_done_a = 1'b0;
        rd_done_b = 1'b0;
        if (access_done && write_in && byteenable_in[0]) begin
            case (address_in)
                dcfm_pkg::OFF_RUN_CTRL: begin
                    run_d = writedata_in[1:0];
                    rewrite_d = writedata_in[1:0];
                    ext_clk_sel_d = writedata_in[dcfm_pkg::POS_EXT_CLK];
                    pin_clr_d = writedata_in[dcfm_pkg::POS_PIN_CLR];
                end
                dcfm_pkg::OFF_FEN_A: fen_a_d = writedata_in[7:0];
                dcfm_pkg::OFF_FEN_B: fen_b_d = writedata_in[7:0];
                dcfm_pkg::OFF_LATCH: latch_d = writedata_in[7:0];
                dcfm_pkg::OFF_MFT: mft_d = writedata_in[7:0];
                default: ;
            endcase
        end
        if (ack_d && read_in) begin
            case (address_in)
                dcfm_pkg::OFF_RUN_CTRL: rdata_d = {28'h0, 1'b0, ext_clk_sel_q, run_q};
                dcfm_pkg::OFF_FEN_A: rdata_d = {24'h0, fen_a_q};
                dcfm_pkg::OFF_FEN_B: rdata_d = {24'h0, fen_b_q};
                dcfm_pkg::OFF_LATCH: rdata_d = {24'h0, latch_q};
                dcfm_pkg::OFF_MFT: rdata_d = {24'h0, mft_q};
                dcfm_pkg::OFF_STAT_A: rdata_d = {23'h0, stat_a_q};
                dcfm_pkg::OFF_STAT_B: rdata_d = {26'h0, stat_b_q};
                dcfm_pkg::OFF_CH_STATE: rdata_d = {24'h0, pin_q, ss_q, 2'(st_q[1]), 2'(st_q[0])};
                default: rdata_d = 32'h0;
            endcase
        end
        if (access_done && read_in) begin
            rd_done_a = (address_in == dcfm_pkg::OFF_STAT_A);
            rd_done_b = (address_in == dcfm_pkg::OFF_STAT_B);
        end
        // Only bits returned in readdata may clear, so a late event survives
        stat_a_d = stat_upd(stat_a_q, rdata_q[8:0], stat_a_now, rd_done_a);
        stat_b_d = 6'(stat_upd({3'h0, stat_b_q}, {3'h0, rdata_q[5:0]}, {3'h0, stat_b_now}, rd_done_b));
    end

    // Channel sequencing, one independent copy per channel
    always_comb begin
        logic nl_off;
        logic nl_timed;
        logic lat_evt;
        logic [3:0] cur;
        logic any_flt;
        nl_off = 1'b0;
        any_flt = 1'b0;
        nl_timed = 1'b0;
        lat_evt = 1'b0;
        cur = 4'h0;
        tro_prev_d = common_in.timing_open;
        for (int i = 0; i < NCH; i++) begin
            st_d[i] = st_q[i];
            cnt_d[i] = cnt_q[i];
            ss_d[i] = 1'b0;
            cur = {oc_flag[i], switch_current_cap_fault_flag[i], lv_flag[i], hv_flag[i]};
            prev_d[i] = cur;
            // Open-pin faults always latch; only a run rewrite recovers
            lat_evt = (hv_flag[i] & ~prev_q[i][0] & ch_bit(latch_q, i, dcfm_pkg::POS_HV_LAT))
                | (lv_flag[i] & ~prev_q[i][1] & ch_bit(latch_q, i, dcfm_pkg::POS_LV_LAT))
                | (switch_current_cap_fault_flag[i] & ~prev_q[i][2] & ch_bit(latch_q, i, dcfm_pkg::POS_SWITCH_CURRENT_CAP_FAULT_LAT))
                | (oc_flag[i] & ~prev_q[i][3] & ch_bit(latch_q, i, dcfm_pkg::POS_OC_LAT))
                | sno_flag[i] | fbo_flag[i] | (common_in.timing_open & ~tro_prev_q);
            // Non-latched faults hold the channel off while present
            nl_off = (hv_flag[i] & ~ch_bit(latch_q, i, dcfm_pkg::POS_HV_LAT))
                | (lv_flag[i] & ~ch_bit(latch_q, i, dcfm_pkg::POS_LV_LAT))
                | (switch_current_cap_fault_flag[i] & ~ch_bit(latch_q, i, dcfm_pkg::POS_SWITCH_CURRENT_CAP_FAULT_LAT))
                | (oc_flag[i] & ~ch_bit(latch_q, i, dcfm_pkg::POS_OC_LAT)) | common_off;
            nl_timed = (lv_flag[i] & ~prev_q[i][1] & ~ch_bit(latch_q, i, dcfm_pkg::POS_LV_LAT))
                | (oc_flag[i] & ~prev_q[i][3] & ~ch_bit(latch_q, i, dcfm_pkg::POS_OC_LAT));
            // A latched fault still present must not let a rewrite restart the channel
            any_flt = hv_flag[i] | lv_flag[i] | switch_current_cap_fault_flag[i] | oc_flag[i] | sno_flag[i] | fbo_flag[i]
                | common_in.timing_open;
            if (nl_timed) begin
                cnt_d[i] = mft_limit(mft_q[i * SW +: 4]);
            end else if (ch_tick_in[i] && cnt_q[i] != '0) begin
                cnt_d[i] = cnt_q[i] - MFT_W'(1);
            end
            case (st_q[i])
                dcfm_pkg::CH_OFF: begin
                    if (run_q[i] && !lat_evt && !nl_off && !any_flt) begin
                        st_d[i] = dcfm_pkg::CH_RUN;
                        ss_d[i] = 1'b1;
                    end
                end
                dcfm_pkg::CH_RUN: begin
                    if (!run_q[i]) begin
                        st_d[i] = dcfm_pkg::CH_OFF;
                    end else if (lat_evt) begin
                        st_d[i] = dcfm_pkg::CH_LATCHED;
                    end else if (nl_off || nl_timed) begin
                        st_d[i] = dcfm_pkg::CH_WAIT;
                    end
                end
                dcfm_pkg::CH_WAIT: begin
                    // Restart waits for the fault to clear and the timer to run out
                    if (!run_q[i]) begin
                        st_d[i] = dcfm_pkg::CH_OFF;
                    end else if (lat_evt) begin
                        st_d[i] = dcfm_pkg::CH_LATCHED;
                    end else if (!nl_off && !nl_timed && cnt_q[i] == '0) begin
                        st_d[i] = dcfm_pkg::CH_RUN;
                        ss_d[i] = 1'b1;
                    end
                end
                dcfm_pkg::CH_LATCHED: begin
                    // Only a fresh run-bit write revives the channel
                    if (rewrite_q[i]) begin
                        st_d[i] = dcfm_pkg::CH_OFF;
                    end else if (!run_q[i]) begin
                        st_d[i] = dcfm_pkg::CH_OFF;
                    end
                end
                default: st_d[i] = dcfm_pkg::CH_OFF;
            endcase
        end
    end

    // Fault pins: sticky until cleared; events win over the clear
    always_comb begin
        logic [1:0] keep;
        keep = pin_clr_q ? 2'h0 : pin_q;
        pin_d = keep | pin_evt;
        ext_clk_d = ext_clk_sel_q & fault_b_in;
        // Pin b turns input; its faults move onto pin a
        if (ext_clk_sel_q) begin
            pin_d[0] = keep[0] | keep[1] | pin_evt[0] | pin_evt[1];
            pin_d[1] = 1'b0;
        end
    end

    // Bus and register state
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            run_q <= 2'h0;
            ext_clk_sel_q <= 1'b0;
            fen_a_q <= dcfm_pkg::RST_FEN_A;
            fen_b_q <= dcfm_pkg::RST_FEN_B;
            latch_q <= dcfm_pkg::RST_LATCH;
            mft_q <= dcfm_pkg::RST_MFT;
            stat_a_q <= 9'h0;
            stat_b_q <= 6'h0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
            rewrite_q <= 2'h0;
            pin_clr_q <= 1'b0;
        end else if (ce_in) begin
            run_q <= run_d;
            ext_clk_sel_q <= ext_clk_sel_d;
            fen_a_q <= fen_a_d;
            fen_b_q <= fen_b_d;
            latch_q <= latch_d;
            mft_q <= mft_d;
            stat_a_q <= stat_a_d;
            stat_b_q <= stat_b_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            rewrite_q <= rewrite_d;
            pin_clr_q <= pin_clr_d;
        end
    end

    // Channel sequencing state
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            tro_prev_q <= 1'b0;
            ss_q <= 2'h0;
            for (int i = 0; i < NCH; i++) begin
                st_q[i] <= dcfm_pkg::CH_OFF;
                cnt_q[i] <= '0;
                prev_q[i] <= 4'h0;
            end
        end else if (ce_in) begin
            tro_prev_q <= tro_prev_d;
            ss_q <= ss_d;
            for (int i = 0; i < NCH; i++) begin
                st_q[i] <= st_d[i];
                cnt_q[i] <= cnt_d[i];
                prev_q[i] <= prev_d[i];
            end
        end
    end

    // Fault pin state
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_q <= 2'h0;
            ext_clk_q <= 1'b0;
        end else if (ce_in) begin
            pin_q <= pin_d;
            ext_clk_q <= ext_clk_d;
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ch_on_out[i] = (st_q[i] == dcfm_pkg::CH_RUN);
        end
    end

    assign readdata_out = rdata_q;
    assign soft_start_out = ss_q;
    assign hv_hyst_out = prev_q[1][0] ? {1'b1, prev_q[0][0]} : {1'b0, prev_q[0][0]};
    // Open-drain: level is always low, enable low pulls the pin
    assign fault_a_out = 1'b0;
    assign fault_b_out = 1'b0;
    assign fault_a_oe_n_out = ~pin_q[0];
    assign fault_b_oe_n_out = ~pin_q[1];
    assign ext_clk_out = ext_clk_q;
endmodule

//--- tb/dcfm_fault_manager_properties.sv
/*
 * Concurrent checks on the fault manager's top-level ports.
 * Assumes ce_in stays high and fault enables keep their reset values.
 */
`timescale 1ns/10ps
module dcfm_fault_manager_properties #(
    parameter int MFT_W = dcfm_pkg::MFT_W
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic waitrequest_out,
    input wire dcfm_pkg::dcfm_ch_cond_t [1:0] ch_cond_in,
    input wire dcfm_pkg::dcfm_common_t common_in,
    input wire logic fault_b_in,
    input wire logic [1:0] ch_on_out,
    input wire logic [1:0] soft_start_out,
    input wire logic [1:0] hv_hyst_out,
    input wire logic fault_a_oe_n_out,
    input wire logic fault_b_oe_n_out,
    input wire logic ext_clk_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    wire req = read_in | write_in;
    AST_WAIT_FIRST: assert property (req && !$past(req) |-> waitrequest_out)
        else $error("request answered without wait");
    AST_ANSWER: assert property (req && waitrequest_out |=> !waitrequest_out)
        else $error("request not answered after one wait");
    AST_HV_OFF: assert property (ch_cond_in[0].hv [*3] |-> !ch_on_out[0])
        else $error("channel a runs with high voltage");
    AST_LV_OFF: assert property ((ch_cond_in[0].lv && !ch_cond_in[0].ramp_busy) [*3] |-> !ch_on_out[0])
        else $error("channel a runs with low voltage");
    AST_HYST: assert property (hv_hyst_out[0] |-> $past(ch_cond_in[0].hv))
        else $error("hysteresis without high voltage");
    AST_PIN_A: assert property (ch_cond_in[0].hv |=> !fault_a_oe_n_out)
        else $error("fault pin a not pulled");
    AST_SHUTDOWN: assert property (common_in.thermal_shutdown [*3] |-> ch_on_out == 2'h0)
        else $error("channel runs in thermal shutdown");
    AST_SOFT: assert property ($rose(ch_on_out[0]) |-> soft_start_out[0] || $past(soft_start_out[0]))
        else $error("start without soft start");
    AST_EXT_COPY: assert property (ext_clk_out |-> $past(fault_b_in))
        else $error("external clock not a copy of pin");
    AST_EXT_IN: assert property (ext_clk_out |-> fault_b_oe_n_out)
        else $error("clock pin driven while input");
    COV_SOFT: cover property (soft_start_out[0]);
    COV_HV_OFF: cover property ($fell(ch_on_out[0]) && ch_cond_in[0].hv);
    COV_EXT: cover property (ext_clk_out);
endmodule

bind dcfm_fault_manager dcfm_fault_manager_properties #(.MFT_W(MFT_W)) u_props (
    .clk_in(clk_in), .rstn_in(rstn_in), .read_in(read_in), .write_in(write_in),
    .waitrequest_out(waitrequest_out), .ch_cond_in(ch_cond_in), .common_in(common_in),
    .fault_b_in(fault_b_in), .ch_on_out(ch_on_out), .soft_start_out(soft_start_out),
    .hv_hyst_out(hv_hyst_out), .fault_a_oe_n_out(fault_a_oe_n_out),
    .fault_b_oe_n_out(fault_b_oe_n_out), .ext_clk_out(ext_clk_out));

//--- tb/dcfm_host_model.sv
/*
 * Avalon-MM host standing for the microcontroller.
 * Assumes one clock; xfer is called from the bench between edges.
 */
`timescale 1ns/10ps
module dcfm_host_model (
    input wire logic clk_in,
    input wire logic waitrequest_in,
    input wire logic [31:0] readdata_in,
    output logic [4:0] address_out,
    output logic read_out,
    output logic write_out,
    output logic [31:0] writedata_out,
    output logic [3:0] byteenable_out
);
    int edges_last = 0;
    initial begin
        address_out = 5'h00;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = 32'h0;
        byteenable_out = 4'hf;
    end
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_in);
        address_out <= a;
        writedata_out <= rd ? ~d : d;
        read_out <= rd;
        write_out <= !rd;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (waitrequest_in !== 1'b0);
        q = readdata_in;
        edges_last = n;
        read_out <= 1'b0;
        write_out <= 1'b0;
        // Idle lines toggle so a stale value is never mistaken for data
        address_out <= ~a;
        writedata_out <= ~writedata_out;
    endtask
endmodule

//--- tb/tb.sv
/*
 * Self-checking bench of the dual channel fault manager.
 * Assumes the host model for bus cycles and the bound port checker.
 */
`timescale 1ns/10ps
module tb;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [1:0] tick = 2'h0;
    logic fault_b = 1'b1;
    dcfm_pkg::dcfm_ch_cond_t [1:0] cond = '0;
    dcfm_pkg::dcfm_common_t com = '0;
    logic [4:0] addr;
    logic rd_s;
    logic wr_s;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] be;
    logic wait_s;
    logic [1:0] on;
    logic [1:0] ss;
    logic [1:0] hyst;
    logic fa_oe_n;
    logic fb_oe_n;
    int err_total = 0;
    int checked = 0;
    int tick_cnt = 0;
    int t0;
    logic [4:0] offs [4] = '{dcfm_pkg::OFF_FEN_A, dcfm_pkg::OFF_FEN_B, dcfm_pkg::OFF_LATCH, dcfm_pkg::OFF_MFT};
    logic [7:0] rsts [4] = '{dcfm_pkg::RST_FEN_A, dcfm_pkg::RST_FEN_B, dcfm_pkg::RST_LATCH, dcfm_pkg::RST_MFT};

    dcfm_host_model host (.clk_in(clk_in), .waitrequest_in(wait_s), .readdata_in(rdata), .address_out(addr),
        .read_out(rd_s), .write_out(wr_s), .writedata_out(wdata), .byteenable_out(be));
    dcfm_fault_manager dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .address_in(addr),
        .read_in(rd_s), .write_in(wr_s), .writedata_in(wdata), .byteenable_in(be), .readdata_out(rdata),
        .waitrequest_out(wait_s), .ch_cond_in(cond), .common_in(com), .ch_tick_in(tick),
        .fault_b_in(fault_b), .ch_on_out(on), .soft_start_out(ss), .hv_hyst_out(hyst), .fault_a_out(),
        .fault_a_oe_n_out(fa_oe_n), .fault_b_out(), .fault_b_oe_n_out(fb_oe_n), .ext_clk_out());

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // Random channel clock; pulses counted as the design sees them
    always @(posedge clk_in) begin
        if (tick[0] === 1'b1)
            tick_cnt <= tick_cnt + 1;
        tick <= 2'($urandom);
    end

    function automatic int mft_limit(input int code);
        return (code == 15) ? 16383 : 1000 + code * 1025;
    endfunction
    function automatic logic [31:0] st(input int ch, input int f);
        return 32'h1 << (3 * ch + f);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t %s seen %h want %h", $time, m, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b0, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        host.xfer(1'b1, a, 32'h0, q);
        chk(q, exp, "read data");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic conclude;
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        err_total++;
        conclude();
    end

    initial begin
        void'($urandom(32'h57fcdd5e));
        cyc(3);
        rstn_in <= 1'b1;
        @(negedge clk_in);
        chk(32'({on, fa_oe_n, fb_oe_n}), 32'h3, "reset outputs");
        for (int i = 0; i < 4; i++)
            rd(offs[i], 32'(rsts[i]));
        // High voltage latched on both channels, driven on channel a only
        wr(dcfm_pkg::OFF_LATCH, 32'h11);
        wr(dcfm_pkg::OFF_RUN_CTRL, 32'h3);
        cyc(4);
        @(negedge clk_in);
        chk(32'(on), 32'h3, "start");
        @(posedge clk_in);
        cond[0].hv <= 1'b1;
        cyc(3);
        @(negedge clk_in);
        chk(32'(on), 32'h2, "latched off");
        chk(32'(hyst[0]), 32'h1, "hysteresis");
        chk(32'(fa_oe_n), 32'h0, "pin a");
        @(posedge clk_in);
        cond[0].hv <= 1'b0;
        cyc(5);
        @(negedge clk_in);
        chk(32'(on), 32'h2, "held off");
        rd(dcfm_pkg::OFF_STAT_A, st(0, 0));
        rd(dcfm_pkg::OFF_STAT_A, 32'h0);
        wr(dcfm_pkg::OFF_RUN_CTRL, 32'hb);
        cyc(4);
        @(negedge clk_in);
        chk(32'({on, fa_oe_n, fb_oe_n}), 32'hf, "rerun and pin clear");
        // Non-latched high voltage: persisting bit, restart on flag fall
        wr(dcfm_pkg::OFF_LATCH, 32'h0);
        @(posedge clk_in);
        cond[0].hv <= 1'b1;
        cyc(3);
        @(negedge clk_in);
        chk(32'(on[0]), 32'h0, "hv off");
        rd(dcfm_pkg::OFF_STAT_A, st(0, 0));
        rd(dcfm_pkg::OFF_STAT_A, st(0, 0));
        @(posedge clk_in);
        cond[0].hv <= 1'b0;
        cyc(5);
        @(negedge clk_in);
        chk(32'(on[0]), 32'h1, "hv restart");
        rd(dcfm_pkg::OFF_STAT_A, st(0, 0));
        rd(dcfm_pkg::OFF_STAT_A, 32'h0);
        // Feedback open has no bit of its own
        @(posedge clk_in);
        cond[1].fb_open <= 1'b1;
        cyc(3);
        cond[1].fb_open <= 1'b0;
        cyc(3);
        rd(dcfm_pkg::OFF_STAT_A, st(1, 0));
        // Low voltage masked in ramp, then timed restart
        @(posedge clk_in);
        cond[0].ramp_busy <= 1'b1;
        cond[0].lv <= 1'b1;
        cyc(4);
        @(negedge clk_in);
        chk(32'(on[0]), 32'h1, "lv masked in ramp");
        @(posedge clk_in);
        cond[0].ramp_busy <= 1'b0;
        cyc(3);
        @(negedge clk_in);
        chk(32'(on[0]), 32'h0, "lv off");
        @(posedge clk_in);
        cond[0].lv <= 1'b0;
        t0 = tick_cnt;
        while (tick_cnt - t0 < mft_limit(0) - 10)
            @(posedge clk_in);
        @(negedge clk_in);
        chk(32'(on[0]), 32'h0, "timer still running");
        while (tick_cnt - t0 < mft_limit(0) + 10)
            @(posedge clk_in);
        @(negedge clk_in);
        chk(32'(on[0]), 32'h1, "timer restart");
        // External clock on pin b; diagnostics keep pins released
        wr(dcfm_pkg::OFF_RUN_CTRL, 32'hf);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_in);
            fault_b <= 1'($urandom);
            cond[0].uc <= 1'($urandom);
            cond[1].uc <= 1'($urandom);
            com.thermal_warning <= 1'($urandom);
        end
        @(posedge clk_in);
        com.thermal_warning <= 1'b1;
        cond[0].uc <= 1'b1;
        cond[1].uc <= 1'b1;
        fault_b <= 1'b1;
        cyc(2);
        @(negedge clk_in);
        chk(32'({on, fa_oe_n, fb_oe_n}), 32'hf, "diagnostics only");
        rd(dcfm_pkg::OFF_STAT_A, st(0, 1) | (32'h1 << dcfm_pkg::POS_ST_TW));
        rd(dcfm_pkg::OFF_STAT_B, st(0, 1) | st(1, 1));
        @(posedge clk_in);
        cond[1].hv <= 1'b1;
        cyc(2);
        @(negedge clk_in);
        chk(32'({fa_oe_n, fb_oe_n}), 32'h1, "faults merged on pin a");
        @(posedge clk_in);
        cond[1].hv <= 1'b0;
        com.thermal_shutdown <= 1'b1;
        cyc(3);
        @(negedge clk_in);
        chk(32'(on), 32'h0, "shutdown both");
        chk(32'(host.edges_last), 32'h2, "one wait state per access");
        conclude();
    end
endmodule
